/* hw/gpib_port_map.vh */
// Constants for the instrument-bus device poll port
`ifndef GPIB_PORT_MAP_VH
`define GPIB_PORT_MAP_VH
// Universal and addressed command bytes (ATN true, low 7 bits)
`define CMD_GTL 7'h01
`define CMD_SDC 7'h04
`define CMD_GET 7'h08
`define CMD_DCL 7'h14
`define CMD_SPE 7'h18
`define CMD_SPD 7'h19
`define CMD_UNL 7'h3f
`define CMD_UNT 7'h5f
// Address group fields
`define GRP_LAG 2'h1
`define GRP_TAG 2'h2
`define GRP_POS 5
`define ADDR_MAX 5'h1e
// Status byte fields
`define STB_RQS_BIT 6
// Host interface owner codes
`define OWN_NONE 2'h0
`define OWN_BUS 2'h1
`define OWN_SER1 2'h2
`define OWN_SER2 2'h3
// Handshake states
`define HS_IDLE 2'h0
`define HS_WAIT 2'h1
`define HS_DONE 2'h2
`define HS_RST 2'h0
`endif

/* hw/bus_handshake.v */
// Acceptor handshake for one byte from the instrument bus
`timescale 1ns/1ps
module bus_handshake (
  // Clock and reset
  input wire CLK,
  input wire SRST,
  // Bus handshake lines, active high logic sense
  input wire dav,
  output wire nrfd,
  output wire ndac,
  input wire enable,
  // Byte strobe to the decoder
  input wire [7:0] dio_in,
  output reg [7:0] byte_reg,
  output reg strobe_reg
);
`include "gpib_port_map.vh"
  reg [1:0] state_reg;
  reg [1:0] state_next;

  // Not ready only while a byte is held; not accepted until latched
  assign nrfd = enable && (state_reg != `HS_IDLE);
  assign ndac = enable && (state_reg != `HS_DONE);

  always @* begin
    state_next = state_reg;
    case (state_reg)
      `HS_IDLE: if (dav && enable) state_next = `HS_WAIT;
      `HS_WAIT: state_next = `HS_DONE;
      `HS_DONE: if (!dav) state_next = `HS_IDLE;
      default: state_next = `HS_IDLE;
    endcase
  end

  // Latch the byte once per handshake cycle
  always @(posedge CLK) begin
    if (SRST) begin
      state_reg <= `HS_RST;
      byte_reg <= 8'h00;
      strobe_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      strobe_reg <= (state_reg == `HS_IDLE) && dav && enable;
      if ((state_reg == `HS_IDLE) && dav && enable) begin
        byte_reg <= dio_in;
      end
    end
  end
endmodule

/* hw/ieee488_device_poll_port.v */
// Device side of the instrument bus: addressing, polls and command decode
//
// Overview of operation
// - Switch address 0 to 30; respond only when that address is used.
// - Internal service condition asserts the service request line.
// - Polled talker after request drives data line seven and releases request.
// - Other status byte lines carry cause bits during serial poll.
// - SPD ends serial poll state; normal talker output resumes.
// - On identify, enabled device drives only its assigned data line.
// - Poll line set only by own setup command; bus configure unsupported.
// - Universal commands apply regardless of addressing, only with attention.
// - Universal device clear resets remote, owner, request, error and poll-line setup; addressing and serial poll stay.
// - Go-to-local while addressed as listener leaves remote for front-panel operation.
// - Selected device clear acts only when addressed as listener.
// - Matching talk group makes talker; matching listen group makes listener.
// - Unlisten drops listener; untalk drops talker addressing.
// - Source, acceptor, talker, listener, request, clear, trigger functions present.
// - Remote and local supported; no local lockout state.
// - Device never acts as bus controller.
// - Once one host interface owns interpreter, others are blocked.
// - Errors summarised in status byte; reading event register clears both.
// - With remote enable, first command enters remote; keys locked.
`timescale 1ns/1ps
module ieee488_device_poll_port #(
  parameter ADDR_W = 5
) (
  // Clock and reset
  input wire CLK,
  input wire SRST,
  // Address switch
  input wire [ADDR_W-1:0] BUS_ADDR,
  // Bus control lines, true sense
  input wire ATN,
  input wire EOI_IN,
  output wire EOI_OUT,
  output wire EOI_OE,
  input wire REN,
  input wire IFC,
  output wire SRQ_OUT,
  output wire SRQ_OE,
  // Data lines
  input wire [7:0] DIO_IN,
  output reg [7:0] DIO_OUT,
  output wire DIO_OE,
  // Handshake lines
  input wire DAV_IN,
  output wire DAV_OUT,
  output wire DAV_OE,
  input wire NRFD_IN,
  output wire NRFD_OUT,
  input wire NDAC_IN,
  output wire NDAC_OUT,
  output wire HS_OE,
  // Instrument side
  input wire SERVICE_REQ,
  input wire [7:0] STATUS_BITS,
  input wire ERROR_EVENT,
  input wire ESR_READ,
  input wire [7:0] TALK_DATA,
  input wire TALK_END,
  input wire TALK_VALID,
  output wire TALK_READY,
  output reg [7:0] LISTEN_DATA,
  output reg LISTEN_VALID,
  input wire CFG_WRITE,
  input wire [2:0] CFG_LINE,
  input wire CFG_ENABLE,
  input wire SER1_CLAIM,
  input wire SER2_CLAIM,
  input wire HOST_RELEASE,
  output wire [1:0] OWNER,
  output wire REMOTE,
  output wire KEYS_LOCKED,
  output reg DEV_CLEAR,
  output reg DEV_TRIGGER,
  output wire ERR_SUMMARY,
  output wire TALKER,
  output wire LISTENER,
  output wire SEQUENTIAL_STATUS_POLL_ACTIVE
);
`include "gpib_port_map.vh"
  reg talk_reg;
  reg listen_reg;
  reg sequential_status_poll_reg;
  reg rqs_reg;
  reg remote_reg;
  reg err_reg;
  reg [1:0] owner_reg;
  reg [2:0] pp_line_reg;
  reg pp_en_reg;
  reg [1:0] sh_reg;
  reg [7:0] sh_data_reg;
  reg sh_end_reg;
  reg sequential_status_poll_sent_reg;
  wire [7:0] cmd_byte;
  wire cmd_strobe;
  wire acc_nrfd;
  wire acc_ndac;
  wire [6:0] cmd;
  wire my_addr;
  wire addr_ok;
  wire identify;
  wire clear_now;
  wire bus_owned;
  wire listen_cmd;
  wire data_strobe;
  wire [7:0] stb;

  // Acceptor runs while listening or under attention
  // Outside those windows it leaves the handshake lines alone, so the
  // other listeners on the bus set the pace of each byte
  bus_handshake u_acceptor (
    .CLK(CLK),
    .SRST(SRST),
    .dav(DAV_IN),
    .nrfd(acc_nrfd),
    .ndac(acc_ndac),
    .enable(ATN || listen_cmd),
    .dio_in(DIO_IN),
    .byte_reg(cmd_byte),
    .strobe_reg(cmd_strobe)
  );

  assign listen_cmd = listen_reg && !ATN;
  assign cmd = cmd_byte[6:0];
  // Addresses above 30 never match; 31 is the unaddress code
  // Group bits are checked by each user of this match, not here
  assign addr_ok = (BUS_ADDR <= `ADDR_MAX);
  assign my_addr = addr_ok && (cmd[4:0] == BUS_ADDR);
  assign identify = ATN && EOI_IN;
  assign bus_owned = (owner_reg == `OWN_NONE) || (owner_reg == `OWN_BUS);
  assign data_strobe = cmd_strobe && !ATN && listen_reg;
  // Device clear from universal or selected command; interface clear only
  // drops addressing, serial poll mode and the talker handshake, it is not a device clear
  assign clear_now = cmd_strobe && ATN && ((cmd == `CMD_DCL) ||
                     ((cmd == `CMD_SDC) && listen_reg));

  // Addressing and poll mode
  // A talk byte for another device unaddresses us, so only one talker exists
  // Listen addressing is additive and is only dropped by unlisten, interface clear or reset
  always @(posedge CLK) begin
    if (SRST || IFC) begin
      talk_reg <= 1'b0;
      listen_reg <= 1'b0;
      sequential_status_poll_reg <= 1'b0;
    end else if (cmd_strobe && ATN) begin
      if (cmd[6:`GRP_POS] == `GRP_TAG) begin
        if (cmd == `CMD_UNT) talk_reg <= 1'b0;
        else if (my_addr) talk_reg <= 1'b1;
        else talk_reg <= 1'b0;
      end
      if (cmd[6:`GRP_POS] == `GRP_LAG) begin
        if (cmd == `CMD_UNL) listen_reg <= 1'b0;
        else if (my_addr) listen_reg <= 1'b1;
      end
      if (cmd == `CMD_SPE) sequential_status_poll_reg <= 1'b1;
      if (cmd == `CMD_SPD) sequential_status_poll_reg <= 1'b0;
    end
  end

  // Remote entry on first command with REN; no lockout state exists
  // Only our own listen byte or any byte taken while listening counts as a command,
  // so universal bytes that happen to share our address bits cannot seize control
  always @(posedge CLK) begin
    if (SRST || !REN) begin
      remote_reg <= 1'b0;
    end else if (clear_now) begin
      remote_reg <= 1'b0;
    end else if (cmd_strobe && ATN && (cmd == `CMD_GTL) && listen_reg) begin
      remote_reg <= 1'b0;
    end else if (cmd_strobe && bus_owned && (listen_reg || (ATN && cmd[6:`GRP_POS] == `GRP_LAG && my_addr))) begin
      remote_reg <= 1'b1;
    end
  end

  // Interpreter owner: first claimer wins until release or clear
  // Serial hosts cannot take over while the bus is remote, and the bus
  // cannot enter remote while a serial host holds the interpreter
  always @(posedge CLK) begin
    if (SRST || HOST_RELEASE || clear_now || (owner_reg == `OWN_BUS && !REN)) begin
      owner_reg <= `OWN_NONE;
    end else if (owner_reg == `OWN_NONE) begin
      if (remote_reg) owner_reg <= `OWN_BUS;
      else if (SER1_CLAIM) owner_reg <= `OWN_SER1;
      else if (SER2_CLAIM) owner_reg <= `OWN_SER2;
    end
  end

  // Request flag and error summary; a new event beats the clear
  // The sent flag stops a still-pending condition from raising the request
  // again right after the poll; it rearms once the condition goes away
  always @(posedge CLK) begin
    if (SRST || clear_now) begin
      rqs_reg <= 1'b0;
      err_reg <= 1'b0;
      sequential_status_poll_sent_reg <= 1'b0;
    end else begin
      if (ERROR_EVENT) err_reg <= 1'b1;
      else if (ESR_READ) err_reg <= 1'b0;
      // Request cleared once status byte was taken in a poll
      if (SERVICE_REQ && !rqs_reg && !sequential_status_poll_sent_reg) rqs_reg <= 1'b1;
      else if (sh_reg == `HS_DONE && sequential_status_poll_reg && !NDAC_IN) rqs_reg <= 1'b0;
      if (!SERVICE_REQ) sequential_status_poll_sent_reg <= 1'b0;
      else if (sh_reg == `HS_DONE && sequential_status_poll_reg && !NDAC_IN) sequential_status_poll_sent_reg <= 1'b1;
    end
  end

  // Poll line configuration, only via own setup command
  // Bus configure bytes are not decoded at all, so they leave this alone
  always @(posedge CLK) begin
    if (SRST || clear_now) begin
      pp_line_reg <= 3'h0;
      pp_en_reg <= 1'b0;
    end else if (CFG_WRITE) begin
      pp_line_reg <= CFG_LINE;
      pp_en_reg <= CFG_ENABLE;
    end
  end

  // Status byte: bit 6 is request, rest cause bits with error summary
  // Error summary shares bit 5 with the cause bits; the instrument keeps it free
  assign stb = {STATUS_BITS[7], rqs_reg, STATUS_BITS[5:0] | {err_reg, 5'h00}};

  // Source handshake: load, assert DAV when ready, drop after accept
  // State 3 parks after an accepted byte; in a serial poll it stays parked
  // until attention returns, so the status byte goes out once per release of attention
  // Limitation: no timeout, a controller that never accepts holds the talker
  always @(posedge CLK) begin
    if (SRST || IFC || ATN || !talk_reg) begin
      sh_reg <= `HS_IDLE;
      sh_data_reg <= 8'h00;
      sh_end_reg <= 1'b0;
    end else begin
      case (sh_reg)
        `HS_IDLE: begin
          if (sequential_status_poll_reg) begin
            sh_data_reg <= stb;
            sh_end_reg <= 1'b0;
            sh_reg <= `HS_WAIT;
          end else if (TALK_VALID) begin
            sh_data_reg <= TALK_DATA;
            sh_end_reg <= TALK_END;
            sh_reg <= `HS_WAIT;
          end
        end
        `HS_WAIT: if (!NRFD_IN) sh_reg <= `HS_DONE;
        `HS_DONE: if (!NDAC_IN) sh_reg <= `HS_RST + 2'h3;
        default: if (NDAC_IN && !sequential_status_poll_reg) sh_reg <= `HS_IDLE;
      endcase
    end
  end

  // Data line drive: talker byte or single poll line on identify
  // Identify overrides talker data; the answer carries no cause information
  always @(posedge CLK) begin
    if (SRST) begin
      DIO_OUT <= 8'h00;
    end else if (identify) begin
      DIO_OUT <= pp_en_reg ? (8'h01 << pp_line_reg) : 8'h00;
    end else begin
      DIO_OUT <= sh_data_reg;
    end
  end

  // Received data and function strobes
  // Trigger needs listener addressing, like the selected clear
  always @(posedge CLK) begin
    if (SRST) begin
      LISTEN_DATA <= 8'h00;
      LISTEN_VALID <= 1'b0;
      DEV_CLEAR <= 1'b0;
      DEV_TRIGGER <= 1'b0;
    end else begin
      LISTEN_VALID <= data_strobe;
      if (data_strobe) LISTEN_DATA <= cmd_byte;
      DEV_CLEAR <= clear_now;
      DEV_TRIGGER <= cmd_strobe && ATN && (cmd == `CMD_GET) && listen_reg;
    end
  end

  // Pin drivers; no controller lines are ever driven
  // Talker output enables follow the addressed role, SRQ_OE follows the request flag, and all are high while driving;
  // the handshake enable covers the acceptor lines only while they may assert
  assign DIO_OE = (identify && pp_en_reg) || (talk_reg && !ATN && sh_reg != `HS_IDLE);
  assign DAV_OUT = (sh_reg == `HS_DONE);
  assign DAV_OE = talk_reg && !ATN;
  assign EOI_OUT = sh_end_reg && (sh_reg == `HS_DONE);
  assign EOI_OE = talk_reg && !ATN;
  assign SRQ_OUT = rqs_reg;
  assign SRQ_OE = rqs_reg;
  assign NRFD_OUT = acc_nrfd;
  assign NDAC_OUT = acc_ndac;
  assign HS_OE = ATN || listen_cmd;
  assign TALK_READY = talk_reg && !ATN && !sequential_status_poll_reg && (sh_reg == `HS_IDLE);
  assign OWNER = owner_reg;
  assign REMOTE = remote_reg;
  assign KEYS_LOCKED = remote_reg;
  assign ERR_SUMMARY = err_reg;
  assign TALKER = talk_reg;
  assign LISTENER = listen_reg;
  assign SEQUENTIAL_STATUS_POLL_ACTIVE = sequential_status_poll_reg;
endmodule

/* dv/ieee488_device_poll_port_props.sv */
// Pin-level checks for the instrument-bus device poll port
`timescale 1ns/1ps
module ieee488_device_poll_port_props #(parameter ADDR_W = 5) (
  // Clock and reset
  input wire CLK, input wire SRST,
  // Bus side
  input wire [ADDR_W-1:0] BUS_ADDR, input wire ATN, input wire EOI_IN, input wire DAV_IN, input wire REN,
  input wire [7:0] DIO_IN, input wire [7:0] DIO_OUT, input wire DIO_OE, input wire DAV_OUT,
  input wire SRQ_OUT, input wire SRQ_OE,
  // Instrument side
  input wire SERVICE_REQ, input wire [7:0] STATUS_BITS, input wire ERROR_EVENT, input wire ESR_READ,
  input wire ERR_SUMMARY, input wire REMOTE, input wire KEYS_LOCKED,
  input wire TALKER, input wire LISTENER, input wire SEQUENTIAL_STATUS_POLL_ACTIVE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  // Addressing only follows a matching group byte under attention
  a_talk_match: assert property ($rose(TALKER) |-> $past(ATN && DIO_IN[6:0] == {2'h2, BUS_ADDR}))
    else $error("talker set without matching talk byte");
  a_listen_match: assert property ($rose(LISTENER) |-> $past(ATN && DIO_IN[6:0] == {2'h1, BUS_ADDR}))
    else $error("listener set without matching listen byte");
  a_addr_range: assert property ($rose(TALKER) || $rose(LISTENER) |-> BUS_ADDR <= 30)
    else $error("address above 30 answered");
  a_unlisten_drop: assert property ($rose(DAV_IN) && ATN && DIO_IN[6:0] == 7'h3f |-> ##[1:5] !LISTENER)
    else $error("unlisten kept listener");
  a_untalk_drop: assert property ($rose(DAV_IN) && ATN && DIO_IN[6:0] == 7'h5f |-> ##[1:5] !TALKER)
    else $error("untalk kept talker");
  a_srq_raise: assert property ($rose(SERVICE_REQ) && !SEQUENTIAL_STATUS_POLL_ACTIVE |-> ##[1:3] (SRQ_OUT && SRQ_OE))
    else $error("service request not signalled");
  a_poll_cause: assert property (SEQUENTIAL_STATUS_POLL_ACTIVE && TALKER && DAV_OUT |->
    DIO_OE && {DIO_OUT[7], DIO_OUT[4:0]} == {STATUS_BITS[7], STATUS_BITS[4:0]})
    else $error("status byte cause bits wrong");
  a_spd_exit: assert property ($rose(DAV_IN) && ATN && DIO_IN[6:0] == 7'h19 |-> ##[1:5] !SEQUENTIAL_STATUS_POLL_ACTIVE)
    else $error("poll disable ignored");
  a_simultaneous_line_poll_onehot: assert property (ATN && EOI_IN && $past(ATN && EOI_IN) && DIO_OE |-> $onehot(DIO_OUT))
    else $error("identify answer not a single line");
  a_err_clear: assert property (ESR_READ && !ERROR_EVENT |=> !ERR_SUMMARY)
    else $error("event read left summary set");
  a_keys_remote: assert property ((KEYS_LOCKED == REMOTE) && (!REMOTE || $past(REN)))
    else $error("key lock or remote state without remote enable");
  // Main scenarios reached
  c_sequential_status_poll: cover property (SEQUENTIAL_STATUS_POLL_ACTIVE && DAV_OUT);
  c_simultaneous_line_poll: cover property (ATN && EOI_IN && DIO_OE);
  c_remote: cover property ($rose(REMOTE));
  c_talk: cover property (!SEQUENTIAL_STATUS_POLL_ACTIVE && TALKER && DAV_OUT);
endmodule

bind ieee488_device_poll_port ieee488_device_poll_port_props #(.ADDR_W(ADDR_W)) u_props (.CLK, .SRST,
  .BUS_ADDR, .ATN, .EOI_IN, .DAV_IN, .REN, .DIO_IN, .DIO_OUT, .DIO_OE, .DAV_OUT, .SRQ_OUT, .SRQ_OE,
  .SERVICE_REQ, .STATUS_BITS, .ERROR_EVENT, .ESR_READ, .ERR_SUMMARY, .REMOTE, .KEYS_LOCKED,
  .TALKER, .LISTENER, .SEQUENTIAL_STATUS_POLL_ACTIVE);

/* dv/gpib_controller_model.sv */
// Behavioural bus controller facing the device port
`timescale 1ns/1ps
module gpib_controller_model (
  // Clock
  input wire CLK,
  // Controller driven lines, true sense
  output reg ATN, output reg EOI_IN, output reg REN, output reg IFC,
  output reg DAV_IN, output reg NRFD_IN, output reg NDAC_IN, output reg [7:0] DIO_IN,
  // Device driven lines
  input wire DAV_OUT, input wire NRFD_OUT, input wire NDAC_OUT, input wire HS_OE, input wire [7:0] DIO_OUT
);
  integer i;
  // Idle bus; controller not ready until it reads
  initial begin
    {ATN, EOI_IN, REN, IFC, DAV_IN, NRFD_IN, NDAC_IN} = 7'h03;
    DIO_IN = 8'h00;
  end
  // One byte out, held until the device stops holding off
  task send(input a, input [7:0] b, output ok);
    begin
      @(negedge CLK);
      ATN = a;
      DIO_IN = b;
      // Data valid once the acceptor shows ready, or after 20 cycles at most
      for (i = 0; i < 20 && HS_OE === 1'b1 && NRFD_OUT === 1'b1; i = i + 1) @(negedge CLK);
      DAV_IN = 1'b1;
      repeat (5) @(negedge CLK);
      ok = 1'b0;
      for (i = 0; i < 20 && !ok; i = i + 1) begin
        if (!(HS_OE === 1'b1 && NDAC_OUT === 1'b1)) ok = 1'b1; else @(negedge CLK);
      end
      DAV_IN = 1'b0;
      DIO_IN = ~b; // Released lines must not keep the last byte
      repeat (4) @(negedge CLK);
    end
  endtask
  // Accept one byte sourced by the device talker
  task read(output [7:0] b, output ok);
    begin
      @(negedge CLK);
      ATN = 1'b0;
      NRFD_IN = 1'b0;
      ok = 1'b0;
      for (i = 0; i < 40 && !ok; i = i + 1) begin
        if (DAV_OUT === 1'b1) ok = 1'b1; else @(negedge CLK);
      end
      b = DIO_OUT;
      NRFD_IN = 1'b1;
      NDAC_IN = 1'b0;
      for (i = 0; i < 40 && DAV_OUT !== 1'b0; i = i + 1) @(negedge CLK);
      if (DAV_OUT !== 1'b0) ok = 1'b0;
      NDAC_IN = 1'b1;
    end
  endtask
endmodule

/* dv/ieee488_device_poll_port_bench.sv */
// Self-checking bench for the device poll port
`timescale 1ns/1ps
module ieee488_device_poll_port_bench;
  reg CLK, SRST, SERVICE_REQ, ERROR_EVENT, ESR_READ, CFG_WRITE, CFG_ENABLE, SER1_CLAIM, SER2_CLAIM, HOST_RELEASE;
  reg [4:0] BUS_ADDR;
  reg [7:0] STATUS_BITS, b, TALK_DATA;
  reg TALK_END, TALK_VALID, eoi_seen;
  reg [2:0] CFG_LINE;
  reg ok;
  reg [15:0] tbl [0:9];
  wire ATN, EOI_IN, REN, IFC, DAV_IN, NRFD_IN, NDAC_IN, DAV_OUT, NDAC_OUT, HS_OE, DIO_OE, SRQ_OUT, SRQ_OE;
  wire REMOTE, KEYS_LOCKED, DEV_CLEAR, DEV_TRIGGER, ERR_SUMMARY, TALKER, LISTENER, SEQUENTIAL_STATUS_POLL_ACTIVE;
  wire NRFD_OUT, TALK_READY, LISTEN_VALID, EOI_OUT, EOI_OE, DAV_OE;
  wire [7:0] DIO_IN, DIO_OUT, LISTEN_DATA;
  wire [1:0] OWNER;
  integer failures = 0, comparisons = 0, clears = 0, trigs = 0, lvs = 0, n;
  // Every device port is driven or watched by the bench
  ieee488_device_poll_port #(.ADDR_W(5)) dut (.CLK, .SRST, .BUS_ADDR, .ATN, .EOI_IN, .EOI_OUT, .EOI_OE,
    .REN, .IFC, .SRQ_OUT, .SRQ_OE, .DIO_IN, .DIO_OUT, .DIO_OE, .DAV_IN, .DAV_OUT, .DAV_OE, .NRFD_IN,
    .NRFD_OUT, .NDAC_IN, .NDAC_OUT, .HS_OE, .SERVICE_REQ, .STATUS_BITS, .ERROR_EVENT, .ESR_READ,
    .TALK_DATA, .TALK_END, .TALK_VALID, .TALK_READY, .LISTEN_DATA, .LISTEN_VALID,
    .CFG_WRITE, .CFG_LINE, .CFG_ENABLE, .SER1_CLAIM, .SER2_CLAIM, .HOST_RELEASE, .OWNER, .REMOTE,
    .KEYS_LOCKED, .DEV_CLEAR, .DEV_TRIGGER, .ERR_SUMMARY, .TALKER, .LISTENER, .SEQUENTIAL_STATUS_POLL_ACTIVE);
  gpib_controller_model ctl (.CLK, .ATN, .EOI_IN, .REN, .IFC, .DAV_IN, .NRFD_IN, .NDAC_IN, .DIO_IN,
    .DAV_OUT, .NRFD_OUT, .NDAC_OUT, .HS_OE, .DIO_OUT);
  // 100 ns clock
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  // Count one-cycle clear, trigger and listen pulses; note an end-marked talk byte
  always @(posedge CLK) begin
    if (DEV_CLEAR === 1'b1) clears = clears + 1;
    if (DEV_TRIGGER === 1'b1) trigs = trigs + 1;
    if (LISTEN_VALID === 1'b1) lvs = lvs + 1;
    if (DAV_OUT === 1'b1 && DAV_OE === 1'b1 && EOI_OUT === 1'b1 && EOI_OE === 1'b1) eoi_seen = 1'b1;
  end
  task tick(input integer k);
    repeat (k) @(negedge CLK);
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  // A stuck handshake counts as a mismatch and ends the run
  task cmd(input a, input [7:0] c);
    begin
      ctl.send(a, c, ok);
      if (!ok) begin
        failures = failures + 1;
        tally_and_finish;
      end
    end
  endtask
  // Rows: address, attention, byte, expected talker and listener
  initial begin
    tbl[0] = {5'h04, 1'b1, 8'h44, 2'h2}; tbl[1] = {5'h04, 1'b1, 8'h5f, 2'h0};
    tbl[2] = {5'h04, 1'b1, 8'h24, 2'h1}; tbl[3] = {5'h04, 1'b1, 8'h3f, 2'h0};
    tbl[4] = {5'h04, 1'b0, 8'h44, 2'h0}; tbl[5] = {5'h04, 1'b1, 8'h45, 2'h0};
    tbl[6] = {5'h1e, 1'b1, 8'h5e, 2'h2}; tbl[7] = {5'h1e, 1'b1, 8'h3e, 2'h3};
    tbl[8] = {5'h1e, 1'b1, 8'h3f, 2'h2}; tbl[9] = {5'h1e, 1'b1, 8'h5f, 2'h0};
  end
  // Main sequence
  initial begin
    {SRST, SERVICE_REQ, ERROR_EVENT, ESR_READ, CFG_WRITE, CFG_ENABLE, SER1_CLAIM, SER2_CLAIM, HOST_RELEASE} = 9'h100;
    BUS_ADDR = 5'h04;
    STATUS_BITS = 8'h05;
    CFG_LINE = 3'h0;
    {TALK_VALID, TALK_END, eoi_seen} = 3'h0;
    TALK_DATA = 8'h00;
    tick(16);
    SRST = 1'b0;
    tick(1);
    chk({TALKER, LISTENER, SEQUENTIAL_STATUS_POLL_ACTIVE, REMOTE, OWNER, ERR_SUMMARY, SRQ_OUT}, 8'h00);
    for (n = 0; n < 10; n = n + 1) begin
      BUS_ADDR = tbl[n][15:11];
      cmd(tbl[n][10], tbl[n][9:2]);
      chk({6'h00, TALKER, LISTENER}, {6'h00, tbl[n][1:0]});
    end
    BUS_ADDR = 5'h04;
    // Remote on first command, local by go-to-local
    ctl.REN = 1'b1;
    cmd(1'b1, 8'h24);
    cmd(1'b0, 8'h41);
    chk(LISTEN_DATA, 8'h41);
    chk(lvs, 8'h01);
    chk({6'h00, REMOTE, KEYS_LOCKED}, 8'h03);
    cmd(1'b1, 8'h01);
    chk({7'h00, REMOTE}, 8'h00);
    // Selected clear and trigger only while listening
    cmd(1'b1, 8'h04);
    cmd(1'b1, 8'h08);
    cmd(1'b1, 8'h3f);
    cmd(1'b1, 8'h04);
    cmd(1'b1, 8'h08);
    chk(clears, 8'h01);
    chk(trigs, 8'h01);
    // Serial poll with a pending request
    SERVICE_REQ = 1'b1;
    tick(3);
    chk({6'h00, SRQ_OE, SRQ_OUT}, 8'h03);
    cmd(1'b1, 8'h18);
    cmd(1'b1, 8'h44);
    chk({7'h00, SEQUENTIAL_STATUS_POLL_ACTIVE}, 8'h01);
    chk({6'h00, DAV_OE, EOI_OE}, 8'h00);
    ctl.read(b, ok);
    chk({7'h00, ok}, 8'h01);
    if (!ok) tally_and_finish;
    chk(b, 8'h45);
    chk({7'h00, eoi_seen}, 8'h00);
    SERVICE_REQ = 1'b0;
    tick(3);
    chk({7'h00, SRQ_OE & SRQ_OUT}, 8'h00);
    cmd(1'b1, 8'h19);
    chk({7'h00, SEQUENTIAL_STATUS_POLL_ACTIVE}, 8'h00);
    // Normal talker byte after the poll, end-marked
    ctl.ATN = 1'b0;
    TALK_DATA = 8'h5a;
    TALK_END = 1'b1;
    TALK_VALID = 1'b1;
    tick(1);
    chk({7'h00, TALK_READY}, 8'h00);
    TALK_VALID = 1'b0;
    TALK_END = 1'b0;
    ctl.read(b, ok);
    chk({7'h00, ok}, 8'h01);
    if (!ok) tally_and_finish;
    chk(b, 8'h5a);
    chk({7'h00, eoi_seen}, 8'h01);
    cmd(1'b1, 8'h5f);
    // Parallel poll on the configured line, gone after device clear
    CFG_LINE = 3'h3;
    CFG_ENABLE = 1'b1;
    CFG_WRITE = 1'b1;
    tick(1);
    CFG_WRITE = 1'b0;
    SERVICE_REQ = 1'b1;
    ctl.EOI_IN = 1'b1;
    tick(4);
    chk(DIO_OE ? DIO_OUT : 8'h00, 8'h08);
    ctl.EOI_IN = 1'b0;
    cmd(1'b1, 8'h14);
    chk(clears, 8'h02);
    ctl.EOI_IN = 1'b1;
    tick(4);
    chk({7'h00, DIO_OE}, 8'h00);
    ctl.EOI_IN = 1'b0;
    // Error summary set by an event, cleared by reading
    ERROR_EVENT = 1'b1;
    tick(1);
    ERROR_EVENT = 1'b0;
    tick(2);
    chk({7'h00, ERR_SUMMARY}, 8'h01);
    ESR_READ = 1'b1;
    tick(1);
    ESR_READ = 1'b0;
    tick(2);
    chk({7'h00, ERR_SUMMARY}, 8'h00);
    // First host to claim keeps the interpreter
    HOST_RELEASE = 1'b1;
    tick(1);
    HOST_RELEASE = 1'b0;
    SER1_CLAIM = 1'b1;
    tick(2);
    SER1_CLAIM = 1'b0;
    SER2_CLAIM = 1'b1;
    cmd(1'b1, 8'h24);
    SER2_CLAIM = 1'b0;
    chk({6'h00, OWNER}, 8'h02);
    HOST_RELEASE = 1'b1;
    tick(1);
    HOST_RELEASE = 1'b0;
    tick(2);
    chk({6'h00, OWNER}, 8'h00);
    // Interface clear drops all addressing
    ctl.IFC = 1'b1;
    tick(1);
    ctl.IFC = 1'b0;
    tick(1);
    chk({6'h00, TALKER, LISTENER}, 8'h00);
    // Reset in mid-run drops addressing
    cmd(1'b1, 8'h44);
    SRST = 1'b1;
    tick(1);
    SRST = 1'b0;
    tick(1);
    chk({6'h00, TALKER, LISTENER}, 8'h00);
    tally_and_finish;
  end
endmodule
